//--- hdl/tccu_pkg.sv
// ****************************************************************
// shared constants and types of the capture/compare unit
// ****************************************************************
package tccu_pkg;

   // register offsets on the byte-wide processor port
   localparam logic [3:0] CAP1_HI_OFS = 4'h0;      // capture_value_high, channel 1
   localparam logic [3:0] CAP1_LO_OFS = 4'h1;      // capture_value_low, channel 1
   localparam logic [3:0] CAP2_HI_OFS = 4'h2;      // capture_value_high, channel 2
   localparam logic [3:0] CAP2_LO_OFS = 4'h3;      // capture_value_low, channel 2
   localparam logic [3:0] CNT_HI_OFS = 4'h4;       // counter high byte, read only
   localparam logic [3:0] CNT_LO_OFS = 4'h5;       // counter low byte, write reloads
   localparam logic [3:0] CMP1_HI_OFS = 4'h8;      // compare_value_high, channel 1
   localparam logic [3:0] CMP1_LO_OFS = 4'h9;      // compare_value_low, channel 1
   localparam logic [3:0] CMP2_HI_OFS = 4'ha;      // compare_value_high, channel 2
   localparam logic [3:0] CMP2_LO_OFS = 4'hb;      // compare_value_low, channel 2
   localparam logic [3:0] CTRL3_OFS = 4'hc;        // timer_ctrl_three
   localparam logic [3:0] CTRL1_OFS = 4'hd;        // timer_ctrl_one
   localparam logic [3:0] STATUS_OFS = 4'he;       // timer_status_reg
   localparam logic [3:0] CTRL2_OFS = 4'hf;        // timer_ctrl_two

   // status bit positions
   localparam int SR_CAP1 = 7;                     // capture_flag 1
   localparam int SR_CMP1 = 6;                     // compare_flag 1
   localparam int SR_CAP2 = 4;                     // capture_flag 2
   localparam int SR_CMP2 = 3;                     // compare_flag 2

   // reset and reload values
   localparam logic [15:0] CMP_RESET = 16'h8000;   // compare registers after reset
   localparam logic [15:0] CNT_RELOAD = 16'hfffc;  // counter reload value
   localparam logic [7:0] CTRL_RESET = 8'h00;      // all control registers
   localparam logic [2:0] DIV2_LAST = 3'h1;        // prescaler end counts
   localparam logic [2:0] DIV4_LAST = 3'h3;
   localparam logic [2:0] DIV8_LAST = 3'h7;

   // timer_ctrl_one fields
   typedef struct packed {
      logic capIrqEn;       // capture_irq_enable
      logic cmpIrqEn;       // compare_irq_enable
      logic rsvd;           // reads zero
      logic forceLvl2;      // force_level_bit 2
      logic forceLvl1;      // force_level_bit 1
      logic outLvl2;        // compare_output_level 2
      logic capEdge1;       // capture_edge_sel 1, 1 = rising
      logic outLvl1;        // compare_output_level 1
   } tccu_ctrl1_type;

   // timer_ctrl_two fields
   typedef struct packed {
      logic pinEn1;         // compare_pin_enable 1
      logic pinEn2;         // compare_pin_enable 2
      logic onePulse;       // single_pulse_select
      logic pwm;            // pwm mode select
      logic clkSelHi;       // timer_clk_sel_hi
      logic clkSelLo;       // timer_clk_sel_lo
      logic capEdge2;       // capture_edge_sel 2, 1 = rising
      logic extEdge;        // ext_count_clock_pin_edge_sel, 1 = rising
   } tccu_ctrl2_type;

   // timer_ctrl_three fields
   typedef struct packed {
      logic [3:0] rsvd;     // reads zero
      logic globalRoute;    // global_irq_route
      logic capRoute;       // capture_irq_route
      logic cmpRoute;       // compare_irq_route
      logic ovfRoute;       // overflow_irq_route
   } tccu_ctrl3_type;

   // interrupt request lines
   typedef struct packed {
      logic capture;        // capture line
      logic compare;        // compare line
      logic overflow;       // overflow line
      logic shared;         // shared line
   } tccu_irq_type;

endpackage

//--- hdl/tccu_top.sv
// What this block does
// - both clock selects one picks external clock
// - external clock edge chosen by edge select
// - counter updates synchronised to system clock
// - capture edge copies counter into capture register
// - per-channel rising or falling capture edge
// - capture sets flag; interrupt when enabled, routed
// - status read then low byte access clears
// - high byte read freezes capture until low
// - match sets flag, interrupt, drives pin level
// - compare every tick; registers reset 8000h
// - compare pin latch low until match
// - status read then low byte clears compare
// - high byte write inhibits compare until low
// - pin disabled: no level, interrupt still
// - force bit copies level, no flag
// - one-pulse: capture 1 reloads, drives level two
// - one-pulse never sets compare flag 1
// - pwm wins over one-pulse
// - pwm: match1 level one, match2 level two, reload
// - pulse length follows compare registers
// - pwm sets no compare flags
// - three lines or one shared line
// - prescaler divides by 2, 4 or 8
`timescale 1ns/1ps
module tccu_top (
   input wire logic clk,                       // system clock, 250 MHz
   input wire logic rstn,                      // asynchronous reset, active low
   input wire logic [3:0] regAddr,             // register offset
   input wire logic [7:0] regWrData,           // write data
   input wire logic regWr,                     // write strobe
   input wire logic regRd,                     // read strobe
   output logic [7:0] regRdData,               // read data, cycle after strobe
   input wire logic extCountClockPin,          // ext_count_clock_pin
   input wire logic [1:0] captureInputPin,     // capture_input_pin 2..1
   input wire logic overflowPending,           // pending overflow request from counter core
   output logic [1:0] compareOutputPin,        // compare_output_pin latch 2..1
   output logic [1:0] compareOutputPinOe,      // compare pin driven by this block
   output tccu_pkg::tccu_irq_type irqOut       // interrupt request lines
);

   // ****************************************************************
   // reset release
   // ****************************************************************
   logic [1:0] rstSync_q;   // release shift register
   logic rstnInt;           // released reset, used everywhere below

   // reset asserts at once, releases after two edges
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstSync_q <= 2'h0;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end
   assign rstnInt = rstSync_q[1];

   // ****************************************************************
   // control registers
   // ****************************************************************
   tccu_pkg::tccu_ctrl1_type ctrl1_q;   // timer_ctrl_one
   tccu_pkg::tccu_ctrl2_type ctrl2_q;   // timer_ctrl_two
   tccu_pkg::tccu_ctrl3_type ctrl3_q;   // timer_ctrl_three
   logic wrCtrl1;
   logic wrCtrl2;
   logic wrCtrl3;
   logic pwmMode;                       // pwm active
   logic opmMode;                       // one-pulse active

   assign wrCtrl1 = regWr && (regAddr == tccu_pkg::CTRL1_OFS);
   assign wrCtrl2 = regWr && (regAddr == tccu_pkg::CTRL2_OFS);
   assign wrCtrl3 = regWr && (regAddr == tccu_pkg::CTRL3_OFS);
   assign pwmMode = ctrl2_q.pwm;
   assign opmMode = ctrl2_q.onePulse && !ctrl2_q.pwm;

   // software writes; reserved bits held at zero
   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         ctrl1_q <= tccu_pkg::CTRL_RESET;
         ctrl2_q <= tccu_pkg::CTRL_RESET;
         ctrl3_q <= tccu_pkg::CTRL_RESET;
      end else begin
         if (wrCtrl1) begin
            ctrl1_q <= regWrData & 8'hdf;
         end
         if (wrCtrl2) begin
            ctrl2_q <= regWrData;
         end
         if (wrCtrl3) begin
            ctrl3_q <= regWrData & 8'h0f;
         end
      end
   end

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [2:0] extSync_q;      // external clock: two sync stages plus history
   logic [2:0] capSync_q [2];  // capture pins: two sync stages plus history

   // only stage 1 and stage 2 are compared; stage 0 feeds stage 1 alone
   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         extSync_q <= 3'h0;
         capSync_q[0] <= 3'h0;
         capSync_q[1] <= 3'h0;
      end else begin
         extSync_q <= {extSync_q[1:0], extCountClockPin};
         capSync_q[0] <= {capSync_q[0][1:0], captureInputPin[0]};
         capSync_q[1] <= {capSync_q[1][1:0], captureInputPin[1]};
      end
   end

   // ****************************************************************
   // timer clock: prescaler or external edge
   // ****************************************************************
   logic [2:0] preCnt_q;   // prescaler count
   logic [2:0] preLast;    // terminal prescaler count
   logic extSel;           // external clock chosen
   logic extRise;
   logic extFall;
   logic tick;             // one timer clock step

   assign extSel = ctrl2_q.clkSelHi && ctrl2_q.clkSelLo;
   assign extRise = extSync_q[1] && !extSync_q[2];
   assign extFall = !extSync_q[1] && extSync_q[2];

   // divide selection from the two clock select bits
   always_comb begin
      unique case ({ctrl2_q.clkSelHi, ctrl2_q.clkSelLo})
         2'b00: preLast = tccu_pkg::DIV2_LAST;
         2'b01: preLast = tccu_pkg::DIV4_LAST;
         default: preLast = tccu_pkg::DIV8_LAST;
      endcase
   end

   // tick at end of prescale or on chosen external edge; the sync stages
   // cannot resolve pulses narrower than the slow-clock limit, hence
   always_comb begin
      if (extSel) begin
         tick = ctrl2_q.extEdge ? extRise : extFall;
      end else begin
         tick = (preCnt_q == preLast);
      end
   end

   // prescaler wraps at its terminal count
   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         preCnt_q <= 3'h0;
      end else if (extSel || preCnt_q >= preLast) begin
         preCnt_q <= 3'h0;
      end else begin
         preCnt_q <= preCnt_q + 3'h1;
      end
   end

   // ****************************************************************
   // edge detect and compare matches
   // ****************************************************************
   logic [15:0] count_q;        // free running counter
   logic [15:0] cmpVal_q [2];   // compare_value 1..2
   logic [1:0] cmpInhibit_q;    // high byte written, low not yet
   logic [1:0] capEdge;         // detected active capture edges
   logic [1:0] match;           // compare match this tick
   logic [1:0] edgeSel;

   assign edgeSel = {ctrl2_q.capEdge2, ctrl1_q.capEdge1};

   // per channel: edge of the chosen polarity and the compare test
   for (genvar i = 0; i < 2; i++) begin : g_chan
      assign capEdge[i] = edgeSel[i] ?
                          (capSync_q[i][1] && !capSync_q[i][2]) :
                          (!capSync_q[i][1] && capSync_q[i][2]);
      assign match[i] = tick && !cmpInhibit_q[i] && (count_q == cmpVal_q[i]);
   end

   // ****************************************************************
   // counter with reloads
   // ****************************************************************
   // reload on low-byte write, on one-pulse trigger, on pwm period end
   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         count_q <= tccu_pkg::CNT_RELOAD;
      end else if (regWr && regAddr == tccu_pkg::CNT_LO_OFS) begin
         count_q <= tccu_pkg::CNT_RELOAD;
      end else if (opmMode && capEdge[0]) begin
         count_q <= tccu_pkg::CNT_RELOAD;
      end else if (pwmMode && match[1]) begin
         count_q <= tccu_pkg::CNT_RELOAD;
      end else if (tick) begin
         count_q <= count_q + 16'h0001;
      end
   end

   // ****************************************************************
   // capture registers
   // ****************************************************************
   logic [15:0] capVal_q [2];   // capture_value 1..2
   logic [1:0] capHold_q;       // high byte read, low not yet

   // latest capture wins unless the pair is half read
   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         capVal_q[0] <= 16'h0000;
         capVal_q[1] <= 16'h0000;
         capHold_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (capEdge[i] && !capHold_q[i]) begin
               capVal_q[i] <= count_q;
            end
         end
         if (regRd && regAddr == tccu_pkg::CAP1_HI_OFS) begin
            capHold_q[0] <= 1'b1;
         end else if (regRd && regAddr == tccu_pkg::CAP1_LO_OFS) begin
            capHold_q[0] <= 1'b0;
         end
         if (regRd && regAddr == tccu_pkg::CAP2_HI_OFS) begin
            capHold_q[1] <= 1'b1;
         end else if (regRd && regAddr == tccu_pkg::CAP2_LO_OFS) begin
            capHold_q[1] <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // compare registers
   // ****************************************************************
   // hardware never alters these; high write inhibits until low write
   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         cmpVal_q[0] <= tccu_pkg::CMP_RESET;
         cmpVal_q[1] <= tccu_pkg::CMP_RESET;
         cmpInhibit_q <= 2'h0;
      end else if (regWr) begin
         unique case (regAddr)
            tccu_pkg::CMP1_HI_OFS: begin
               cmpVal_q[0][15:8] <= regWrData;
               cmpInhibit_q[0] <= 1'b1;
            end
            tccu_pkg::CMP1_LO_OFS: begin
               cmpVal_q[0][7:0] <= regWrData;
               cmpInhibit_q[0] <= 1'b0;
            end
            tccu_pkg::CMP2_HI_OFS: begin
               cmpVal_q[1][15:8] <= regWrData;
               cmpInhibit_q[1] <= 1'b1;
            end
            tccu_pkg::CMP2_LO_OFS: begin
               cmpVal_q[1][7:0] <= regWrData;
               cmpInhibit_q[1] <= 1'b0;
            end
            default: begin
               // other registers handled elsewhere
            end
         endcase
      end
   end

   // ****************************************************************
   // status flags with two-step clear
   // ****************************************************************
   logic [1:0] capFlag_q;      // capture_flag 1..2
   logic [1:0] cmpFlag_q;      // compare_flag 1..2
   logic [1:0] capArm_q;       // status seen with capture flag set
   logic [1:0] cmpArm_q;       // status seen with compare flag set
   logic [1:0] capFlagSet;
   logic [1:0] cmpFlagSet;
   logic [1:0] capLoAcc;       // access to capture low byte
   logic [1:0] cmpLoAcc;       // access to compare low byte
   logic srRead;
   logic anyAcc;

   assign anyAcc = regRd || regWr;
   assign srRead = regRd && (regAddr == tccu_pkg::STATUS_OFS);
   assign capLoAcc = {anyAcc && regAddr == tccu_pkg::CAP2_LO_OFS,
                      anyAcc && regAddr == tccu_pkg::CAP1_LO_OFS};
   assign cmpLoAcc = {anyAcc && regAddr == tccu_pkg::CMP2_LO_OFS,
                      anyAcc && regAddr == tccu_pkg::CMP1_LO_OFS};
   assign capFlagSet = capEdge;
   // forced level never sets a flag; pwm sets neither, one-pulse not flag 1
   assign cmpFlagSet = {match[1] && !pwmMode,
                        match[0] && !pwmMode && !opmMode};

   // a set in the clear cycle wins over the clear
   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         capFlag_q <= 2'h0;
         cmpFlag_q <= 2'h0;
         capArm_q <= 2'h0;
         cmpArm_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (capFlagSet[i]) begin
               capFlag_q[i] <= 1'b1;
            end else if (capArm_q[i] && capLoAcc[i]) begin
               capFlag_q[i] <= 1'b0;
            end
            if (srRead && capFlag_q[i]) begin
               capArm_q[i] <= 1'b1;
            end else if (capLoAcc[i]) begin
               capArm_q[i] <= 1'b0;
            end
            if (cmpFlagSet[i]) begin
               cmpFlag_q[i] <= 1'b1;
            end else if (cmpArm_q[i] && cmpLoAcc[i]) begin
               cmpFlag_q[i] <= 1'b0;
            end
            if (srRead && cmpFlag_q[i]) begin
               cmpArm_q[i] <= 1'b1;
            end else if (cmpLoAcc[i]) begin
               cmpArm_q[i] <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // compare pin latches
   // ****************************************************************
   logic [1:0] pinEn;
   logic [1:0] outLvl;
   logic [1:0] forceLvl;

   assign pinEn = {ctrl2_q.pinEn2, ctrl2_q.pinEn1};
   assign outLvl = {ctrl1_q.outLvl2, ctrl1_q.outLvl1};
   assign forceLvl = {ctrl1_q.forceLvl2, ctrl1_q.forceLvl1};

   // latch low in reset; a disabled pin stays general i/o and keeps its latch
   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         compareOutputPin <= 2'h0;
         compareOutputPinOe <= 2'h0;
      end else begin
         compareOutputPinOe <= pinEn;
         // pin 1: forced level, then mode-specific sources
         if (!pinEn[0]) begin
            compareOutputPin[0] <= compareOutputPin[0];
         end else if (forceLvl[0]) begin
            compareOutputPin[0] <= outLvl[0];
         end else if (pwmMode && match[1]) begin
            compareOutputPin[0] <= outLvl[1];
         end else if (pwmMode && match[0]) begin
            compareOutputPin[0] <= outLvl[0];
         end else if (opmMode && capEdge[0]) begin
            compareOutputPin[0] <= outLvl[1];
         end else if (match[0]) begin
            compareOutputPin[0] <= outLvl[0];
         end
         // pin 2: forced level, then ordinary compare; no match source in pwm mode
         if (!pinEn[1]) begin
            compareOutputPin[1] <= compareOutputPin[1];
         end else if (forceLvl[1]) begin
            compareOutputPin[1] <= outLvl[1];
         end else if (match[1] && !pwmMode) begin
            compareOutputPin[1] <= outLvl[1];
         end
      end
   end

   // ****************************************************************
   // interrupt routing
   // ****************************************************************
   logic capReq;
   logic cmpReq;

   // requests stay pending in the flags until enable and route agree
   assign capReq = |capFlag_q && ctrl1_q.capIrqEn;
   assign cmpReq = |cmpFlag_q && ctrl1_q.cmpIrqEn;

   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         irqOut <= 4'h0;
      end else if (ctrl3_q.globalRoute) begin
         irqOut.capture <= 1'b0;
         irqOut.compare <= 1'b0;
         irqOut.overflow <= 1'b0;
         irqOut.shared <= capReq || cmpReq || overflowPending;
      end else begin
         irqOut.capture <= capReq && ctrl3_q.capRoute;
         irqOut.compare <= cmpReq && ctrl3_q.cmpRoute;
         irqOut.overflow <= overflowPending && ctrl3_q.ovfRoute;
         irqOut.shared <= 1'b0;
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************
   logic [7:0] rdMux;

   // unmapped offsets read zero
   always_comb begin
      unique case (regAddr)
         tccu_pkg::CAP1_HI_OFS: rdMux = capVal_q[0][15:8];
         tccu_pkg::CAP1_LO_OFS: rdMux = capVal_q[0][7:0];
         tccu_pkg::CAP2_HI_OFS: rdMux = capVal_q[1][15:8];
         tccu_pkg::CAP2_LO_OFS: rdMux = capVal_q[1][7:0];
         tccu_pkg::CNT_HI_OFS: rdMux = count_q[15:8];
         tccu_pkg::CNT_LO_OFS: rdMux = count_q[7:0];
         tccu_pkg::CMP1_HI_OFS: rdMux = cmpVal_q[0][15:8];
         tccu_pkg::CMP1_LO_OFS: rdMux = cmpVal_q[0][7:0];
         tccu_pkg::CMP2_HI_OFS: rdMux = cmpVal_q[1][15:8];
         tccu_pkg::CMP2_LO_OFS: rdMux = cmpVal_q[1][7:0];
         tccu_pkg::CTRL1_OFS: rdMux = ctrl1_q;
         tccu_pkg::CTRL2_OFS: rdMux = ctrl2_q;
         tccu_pkg::CTRL3_OFS: rdMux = ctrl3_q;
         tccu_pkg::STATUS_OFS: rdMux = {capFlag_q[0], cmpFlag_q[0], 1'b0,
                                        capFlag_q[1], cmpFlag_q[1], 3'h0};
         default: rdMux = 8'h00;
      endcase
   end

   // data valid only the cycle after the strobe, zero otherwise
   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         regRdData <= rdMux;
      end else begin
         regRdData <= 8'h00;
      end
   end

endmodule // tccu_top

//--- verification/tccu_monitor.sv
`timescale 1ns/1ps
// ****
// checks at the top ports
// ****
module tccu_monitor (
   input wire logic clk, // system clock
   input wire logic rstn, // reset, active low
   input wire logic [3:0] regAddr, // offset
   input wire logic [7:0] regWrData, // write data
   input wire logic regWr, // write strobe
   input wire logic overflowPending, // overflow request
   input wire logic [1:0] compareOutputPin, // pin latches
   input wire logic [1:0] compareOutputPinOe, // pin enables
   input wire tccu_pkg::tccu_irq_type irqOut // request lines
);
   tccu_pkg::tccu_ctrl1_type ctl1_q; // shadow of ctrl one
   tccu_pkg::tccu_ctrl2_type ctl2_q; // shadow of ctrl two
   tccu_pkg::tccu_ctrl3_type ctl3_q; // shadow of ctrl three
   // follow control writes so checks know the mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) {ctl1_q, ctl2_q, ctl3_q} <= '0;
      else if (regWr && regAddr == tccu_pkg::CTRL1_OFS) ctl1_q <= regWrData;
      else if (regWr && regAddr == tccu_pkg::CTRL2_OFS) ctl2_q <= regWrData;
      else if (regWr && regAddr == tccu_pkg::CTRL3_OFS) ctl3_q <= regWrData;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // two settled cycles, so a one-flop pin path has caught up
   sequence s_force1; (ctl1_q.forceLvl1 && ctl2_q.pinEn1 && $stable(ctl1_q)) [*2]; endsequence
   property p_pin_rst; $rose(rstn) |-> compareOutputPin == 2'h0; endproperty
   a_pin_rst: assert property (p_pin_rst) else $error("pin not low");
   property p_force; s_force1 |-> compareOutputPin[0] == ctl1_q.outLvl1; endproperty
   a_force: assert property (p_force) else $error("force level");
   property p_oe_off; !ctl2_q.pinEn1 [*2] |-> !compareOutputPinOe[0]; endproperty
   a_oe_off: assert property (p_oe_off) else $error("pin driven");
   property p_glob_excl; irqOut.shared |-> !(irqOut.capture || irqOut.compare); endproperty
   a_glob_excl: assert property (p_glob_excl) else $error("shared line");
   property p_glob_on; $past(overflowPending && ctl3_q.globalRoute) |-> irqOut.shared; endproperty
   a_glob_on: assert property (p_glob_on) else $error("shared idle");
   property p_ovf; irqOut.overflow |-> $past(overflowPending && ctl3_q.ovfRoute); endproperty
   a_ovf: assert property (p_ovf) else $error("overflow line");
   property p_cap; irqOut.capture |-> $past(ctl1_q.capIrqEn && ctl3_q.capRoute); endproperty
   a_cap: assert property (p_cap) else $error("capture line");
   property p_cmp; irqOut.compare |-> $past(ctl1_q.cmpIrqEn && ctl3_q.cmpRoute); endproperty
   a_cmp: assert property (p_cmp) else $error("compare line");
endmodule // tccu_monitor

//--- verification/tccu_pins.sv
`timescale 1ns/1ps
// ****
// count clock source, still while idle
// ****
module tccu_pins (
   input wire logic clk, // system clock
   input wire logic extRun, // let the clock run
   output logic extCountClockPin // count clock
);
   logic [2:0] div_q = 3'h0; // eight-cycle period
   // slow enough that edges never crowd the sync
   always @(posedge clk) begin
      if (extRun) div_q <= div_q + 3'h1;
   end
   assign extCountClockPin = div_q[2];
endmodule // tccu_pins

//--- verification/tccu_bench.sv
`timescale 1ns/1ps
module tccu_bench;
   import tccu_pkg::*;
   logic clk = 1'b0, rstn, regWr, regRd, extPin, ovf, extRun; // stimulus
   logic [3:0] regAddr; // offset
   logic [7:0] regWrData, regRdData, d, hi; // bus data
   logic [1:0] capPin, cmpPin, cmpOe; // pins
   tccu_irq_type irq; // request lines
   int error_cnt = 0, num_checks = 0; // verdict counters
   // reset values: offset beside expected byte
   logic [11:0] rows [9] = '{12'h880, 12'h900, 12'ha80, 12'hb00, 12'hc00,
      12'hd00, 12'he00, 12'hf00, 12'h600};
   tccu_top u_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .extCountClockPin(extPin),
      .captureInputPin(capPin), .overflowPending(ovf), .compareOutputPin(cmpPin),
      .compareOutputPinOe(cmpOe), .irqOut(irq));
   tccu_pins u_pins (.clk(clk), .extRun(extRun), .extCountClockPin(extPin));
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      {regWr, regAddr, regWrData} <= {1'b1, a, v};
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      {regRd, regAddr} <= {1'b1, a};
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   task automatic finish_test;
      if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial forever #2 clk = ~clk;
   initial begin
      repeat (4000) @(posedge clk);
      error_cnt++;
      finish_test;
   end
   initial begin
      {rstn, regWr, regRd, regAddr, regWrData, capPin, ovf, extRun} = '0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      chk("pins", {6'h0, cmpPin}, 8'h00);
      foreach (rows[i]) begin
         rd(rows[i][11:8]);
         chk("reset", d, rows[i][7:0]);
      end
      // forced level on pin one, no flag
      wr(CTRL2_OFS, 8'h80);
      wr(CTRL1_OFS, 8'h09);
      repeat (3) @(posedge clk);
      chk("force", {4'h0, cmpOe, cmpPin}, 8'h05);
      wr(CTRL1_OFS, 8'h08);
      rd(STATUS_OFS);
      chk("force", {d[7:1], cmpPin[0]}, 8'h00);
      // high byte alone holds matching off
      wr(CTRL3_OFS, 8'h02);
      wr(CTRL1_OFS, 8'h41);
      wr(CMP1_HI_OFS, 8'h00);
      wr(CNT_LO_OFS, 8'h00);
      repeat (40) @(posedge clk);
      rd(STATUS_OFS);
      chk("inhibit", {d[7:1], cmpPin[0]}, 8'h00);
      wr(CMP1_LO_OFS, 8'h30);
      repeat (100) @(posedge clk);
      chk("match", {6'h0, irq.compare, cmpPin[0]}, 8'h03);
      rd(STATUS_OFS);
      chk("cmp flag", d, 8'h40);
      rd(CMP1_LO_OFS);
      rd(STATUS_OFS);
      chk("cmp clear", d, 8'h00);
      // capture on rising, frozen after a high read
      wr(CTRL1_OFS, 8'h82);
      wr(CTRL3_OFS, 8'h04);
      wr(CNT_LO_OFS, 8'h00);
      repeat (10) @(posedge clk);
      capPin <= 2'h1;
      repeat (8) @(posedge clk);
      chk("cap irq", {7'h0, irq.capture}, 8'h01);
      rd(STATUS_OFS);
      chk("cap flag", d, 8'h80);
      rd(CAP1_HI_OFS);
      chk("cap hi", d, 8'h00);
      capPin <= 2'h0;
      repeat (5) @(posedge clk);
      capPin <= 2'h1;
      repeat (8) @(posedge clk);
      rd(CAP1_LO_OFS);
      chk("cap lo", 8'(d inside {[8'h01:8'h05]}), 8'h01);
      capPin <= 2'h0;
      repeat (8) @(posedge clk);
      rd(STATUS_OFS);
      chk("cap clear", d, 8'h00);
      // shared line, then separate overflow line
      wr(CTRL3_OFS, 8'h08);
      ovf <= 1'b1;
      repeat (3) @(posedge clk);
      chk("global", {4'h0, irq}, 8'h01);
      wr(CTRL3_OFS, 8'h01);
      repeat (3) @(posedge clk);
      chk("separate", {4'h0, irq}, 8'h02);
      ovf <= 1'b0;
      // pwm with one-pulse also set: high for (4+5) ticks of 15
      wr(CMP1_LO_OFS, 8'h04);
      wr(CMP2_HI_OFS, 8'h00);
      wr(CMP2_LO_OFS, 8'h0a);
      wr(CTRL1_OFS, 8'h04);
      wr(CTRL2_OFS, 8'hb0);
      wr(CNT_LO_OFS, 8'h00);
      repeat (40) @(posedge clk);
      hi = 8'h00;
      #1;
      repeat (60) begin
         #4 hi = hi + 8'(cmpPin[0]);
      end
      chk("pwm high", hi, 8'h24);
      rd(STATUS_OFS);
      chk("pwm flags", d, 8'h00);
      // external rising edges: ten in eighty cycles
      wr(CTRL2_OFS, 8'h0d);
      wr(CNT_LO_OFS, 8'h00);
      extRun <= 1'b1;
      repeat (80) @(posedge clk);
      extRun <= 1'b0;
      repeat (12) @(posedge clk);
      rd(CNT_HI_OFS);
      hi = d;
      rd(CNT_LO_OFS);
      chk("ext count", hi | (d ^ 8'h06), 8'h00);
      finish_test;
   end
endmodule // tccu_bench
bind tccu_top tccu_monitor u_mon (.clk(clk), .rstn(rstn), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .overflowPending(overflowPending),
   .compareOutputPin(compareOutputPin), .compareOutputPinOe(compareOutputPinOe),
   .irqOut(irqOut));
